// [core/srma_device.sv]
// register bank behind the serial control port of the supply chip.
// assumes a link clock far slower than clk; mode and fault inputs come
// from logic on clk.
//
// Notes on behaviour
// R1 - address 6:0, selector 7, data 15:8
// R2 - 0x00..0x1e are read/write control registers
// R3 - selector zero reads, one writes and returns
// R4 - written value shows only in later frames
// R5 - 0x40..0x7e are status, read or clear
// R6 - master sets selector to clear status
// R7 - level, identity, filter registers ignore clears
// R8 - drivers enable even while failure flags set
// R9 - mode field follows the mode entered
// R10 - low power keeps diagnosis and fail output
// R11 - stop mode leaves transceiver bits alone
// R12 - sleep forces active transceiver to wake-capable
// R13 - switch and supply config only in normal
// R14 - faults switch output off, no wake
// R15 - restart clears switch and second supply config
// R16 - hardware may modify some control bits
// R17 - frames ignored during restart mode; here only writes and clears are dropped, reads are still answered
// R18 - summary byte flags nonzero status registers
// R19 - bad clock count discards frame, flags error
// R20 - reserved read zero, unused addresses inert
`timescale 1ns/1ps
module srma_device
    import srma_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link
    srma_link_if.dev link,
    // mode reports from the chip state machine
    input wire logic mode_chg,
    input wire logic [1:0] mode_in,
    // status events and live levels
    input wire logic [8*STAT_N-1:0] stat_evt,
    input wire logic [8*LIVE_N-1:0] live_in,
    input wire logic [3:0] hs_fault,
    input wire logic fail_trig,
    // configuration and state
    output logic [8*CTRL_N-1:0] ctrl_cfg,
    output logic fail_output,
    output logic frame_err
);

    // ------------------------------------------------------------
    // decode functions
    // ------------------------------------------------------------
    function automatic logic [7:0] wmask(input logic [6:0] a);
        if (a == A_MODE_SUPPLY) wmask = M_ALL;
        else if (a == A_HW_CFG) wmask = M_HW_CFG;
        else if (a == A_WDOG_CFG) wmask = M_WDOG_CFG;
        else if (a == A_BUS_CFG_A) wmask = M_BUS_CFG_A;
        else if (a == A_BUS_CFG_B) wmask = M_BUS_CFG_B;
        else if (a == A_WAKE_CFG_A) wmask = M_WAKE_CFG_A;
        else if (a == A_WAKE_CFG_B) wmask = M_ALL;
        else if (a == A_WAKE_PULL) wmask = M_WAKE_LOW6;
        else if (a == A_WAKE_FILT) wmask = M_WAKE_LOW6;
        else if (a == A_TIMER_A || a == A_TIMER_B) wmask = M_TIMER;
        else if (a == A_SW_SHUTDOWN) wmask = M_SW_SHUTDOWN;
        else if (a == A_HS_CFG_A || a == A_HS_CFG_B) wmask = M_HS_CFG;
        else if (a == A_GPIO_CFG) wmask = M_ALL;
        else if (a == A_PWM_A || a == A_PWM_B) wmask = M_ALL;
        else if (a == A_PWM_FREQ) wmask = M_PWM_FREQ;
        else if (a == A_SCRATCH) wmask = M_ALL;
        else wmask = M_NONE;
    endfunction

    // index of a clearable status register, STAT_N when none
    function automatic logic [3:0] stat_idx(input logic [6:0] a);
        if (a == A_SUPPLY_B) stat_idx = 4'h0;
        else if (a == A_SUPPLY_A) stat_idx = 4'h1;
        else if (a == A_THERMAL) stat_idx = 4'h2;
        else if (a == A_DEVICE) stat_idx = 4'h3;
        else if (a == A_BUS_FAIL) stat_idx = 4'h4;
        else if (a == A_WAKE_SRC_A) stat_idx = 4'h5;
        else if (a == A_WAKE_SRC_B) stat_idx = 4'h6;
        else if (a == A_HS_OVERLOAD) stat_idx = 4'h7;
        else if (a == A_HS_OPENLOAD) stat_idx = 4'h8;
        else stat_idx = 4'(STAT_N);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisation and edges
    // ------------------------------------------------------------
    logic s_sclk;
    logic s_csn;
    logic s_mosi;
    logic sclk_q_r;
    logic csn_q_r;

    srma_sync #(.W(3), .INIT(3'h2)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({link.sclk, link.csn_n, link.mosi}),
        .q({s_sclk, s_csn, s_mosi})
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q_r <= 1'b0;
            csn_q_r <= 1'b1;
        end else begin
            sclk_q_r <= s_sclk;
            csn_q_r <= s_csn;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic csn_fall;
    logic csn_rise;
    assign sclk_rise = s_sclk & ~sclk_q_r & ~s_csn;
    assign sclk_fall = ~s_sclk & sclk_q_r & ~s_csn;
    assign csn_fall = csn_q_r & ~s_csn;
    assign csn_rise = ~csn_q_r & s_csn;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] ctrl_r [CTRL_N];
    logic [7:0] ctrl_nxt [CTRL_N];
    logic [7:0] stat_r [STAT_N];
    logic [7:0] stat_nxt [STAT_N];
    logic [15:0] shift_r, shift_nxt;
    logic [15:0] resp_r, resp_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic hi_r, hi_nxt;
    logic err_r, err_nxt;
    logic miso_r, miso_nxt;
    logic fail_r, fail_nxt;

    logic [7:0] summary;
    logic restart_mode;
    logic normal_mode;
    assign restart_mode = ctrl_r[0][MODE_LSB +: 2] == SRMA_RESTART;
    assign normal_mode = ctrl_r[0][MODE_LSB +: 2] == SRMA_NORMAL;

    // one summary bit per status register, pair ORed [R18]
    always_comb begin
        summary[0] = |stat_r[1];
        summary[1] = |stat_r[2];
        summary[2] = |stat_r[3];
        summary[3] = |stat_r[4];
        summary[4] = |stat_r[5] | |stat_r[6];
        summary[5] = |stat_r[0];
        summary[6] = |stat_r[7];
        summary[7] = |stat_r[8];
    end

    function automatic logic [7:0] read_byte(input logic [6:0] a,
                                             input logic [7:0] c,
                                             input logic [7:0] s,
                                             input logic [39:0] lv);
        if (a <= CTRL_LAST) read_byte = c & wmask(a); // [R20]
        else if (stat_idx(a) != 4'(STAT_N)) read_byte = s;
        else if (a == A_WAKE_LEVEL) read_byte = lv[7:0]; // [R7]
        else if (a == A_SW_FILTER) read_byte = lv[15:8];
        else if (a == A_SW_ERRCNT) read_byte = lv[23:16];
        else if (a == A_SW_CLKREC_A) read_byte = lv[31:24];
        else if (a == A_SW_CLKREC_B) read_byte = lv[39:32];
        else if (a == A_FAMILY_ID) read_byte = FAMILY_ID_VAL;
        else read_byte = 8'h00;
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [6:0] a;
        logic [7:0] d;
        logic [7:0] m;
        logic [7:0] clr [STAT_N];
        logic [3:0] si;
        a = shift_r[ADDR_LSB +: ADDR_W];
        d = shift_r[DATA_LSB +: 8];
        m = wmask(a);
        si = stat_idx(a);
        for (int i = 0; i < STAT_N; i++) clr[i] = 8'h00;
        ctrl_nxt = ctrl_r;
        shift_nxt = shift_r;
        resp_nxt = resp_r;
        cnt_nxt = cnt_r;
        hi_nxt = hi_r;
        err_nxt = err_r;
        miso_nxt = miso_r;
        fail_nxt = fail_r | fail_trig; // [R10] [R15]

        if (csn_fall) begin
            cnt_nxt = 5'h00;
            hi_nxt = s_sclk;
            resp_nxt = {8'h00, summary};
            miso_nxt = err_r | summary[0]; // [R19]
        end else if (sclk_rise) begin
            shift_nxt = {s_mosi, shift_r[15:1]};
            if (cnt_r != 5'h1f) cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == 5'h07) begin
                // register byte answered in the same frame [R3] [R4]
                resp_nxt[15:8] = read_byte(shift_nxt[14:8],
                    ctrl_r[shift_nxt[12:8]], stat_r[stat_idx(
                    shift_nxt[14:8])], live_in);
            end
        end else if (sclk_fall) begin
            if (cnt_r < FRAME_CNT) miso_nxt = resp_r[cnt_r[3:0]];
        end else if (csn_rise) begin
            miso_nxt = 1'b0;
            // discard on wrong count or clock high at a chip-select edge
            err_nxt = (cnt_r != FRAME_CNT && cnt_r != 5'h00) | hi_r
                | s_sclk; // [R19]
            if (cnt_r == FRAME_CNT && !hi_r && !s_sclk
                && !restart_mode) begin // [R17]
                if (a <= CTRL_LAST && shift_r[SEL_POS]) begin // [R1] [R2]
                    if (!normal_mode) begin
                        if (a == A_HS_CFG_A || a == A_HS_CFG_B)
                            m = M_NONE; // [R13]
                        else if (a == A_MODE_SUPPLY)
                            m = m & ~M_SUPPLY_CFG; // [R13]
                    end
                    ctrl_nxt[a[4:0]] = (ctrl_r[a[4:0]] & ~m) | (d & m);
                end else if (a >= STAT_FIRST && a <= STAT_LAST
                             && shift_r[SEL_POS]
                             && si != 4'(STAT_N)) begin // [R5] [R6] [R7]
                    clr[si] = 8'hff;
                end
            end
        end

        // hardware-updatable control bits [R16]
        if (mode_chg) begin
            ctrl_nxt[0][MODE_LSB +: 2] = mode_in; // [R9]
            if (mode_in == SRMA_SLEEP) begin
                if (ctrl_nxt[3][2:0] != CAN_OFF
                    && ctrl_nxt[3][2:0] != CAN_WAKE_CAPABLE)
                    ctrl_nxt[3][2:0] = CAN_WAKE_CAPABLE; // [R12]
            end else if (mode_in == SRMA_RESTART) begin
                ctrl_nxt[A_HS_CFG_A[4:0]] = 8'h00; // [R15]
                ctrl_nxt[A_HS_CFG_B[4:0]] = 8'h00;
                ctrl_nxt[0] = ctrl_nxt[0] & ~M_SECOND_SUPPLY;
            end
            // stop keeps transceiver bits, status untouched [R11] [R10]
        end
        // faulted switch turned off, no wake raised [R14]
        for (int h = 0; h < 4; h++) begin
            if (hs_fault[h])
                ctrl_nxt[A_HS_CFG_A[4:0] + 5'(h / 2)][HS_FIELD_W*(h%2) +: 3]
                    = 3'h0;
        end
        // set wins over clear; drivers stay enableable [R8]
        for (int i = 0; i < STAT_N; i++)
            stat_nxt[i] = (stat_r[i] & ~clr[i]) | stat_evt[8*i +: 8];
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < CTRL_N; i++) ctrl_r[i] <= 8'h00;
            for (int i = 0; i < STAT_N; i++) stat_r[i] <= 8'h00;
            shift_r <= 16'h0000;
            resp_r <= 16'h0000;
            cnt_r <= 5'h00;
            hi_r <= 1'b0;
            err_r <= 1'b0;
            miso_r <= 1'b0;
            fail_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            stat_r <= stat_nxt;
            shift_r <= shift_nxt;
            resp_r <= resp_nxt;
            cnt_r <= cnt_nxt;
            hi_r <= hi_nxt;
            err_r <= err_nxt;
            miso_r <= miso_nxt;
            fail_r <= fail_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < CTRL_N; g++) begin : g_cfg
            assign ctrl_cfg[8*g +: 8] = ctrl_r[g];
        end
    endgenerate

    assign link.miso = miso_r;
    assign fail_output = fail_r;
    assign frame_err = err_r;

endmodule

// [core/srma_host.sv]
// serial master that sends one frame per software command.
// assumes the device answers each bit within half a link period.
`timescale 1ns/1ps
module srma_host
    import srma_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link
    srma_link_if.host link,
    // software port
    input wire logic [1:0] sw_addr,
    input wire logic [15:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [15:0] sw_rdata
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SRMA_IDLE, SRMA_LEAD, SRMA_HIGH, SRMA_LOW, SRMA_TRAIL, SRMA_GAP
    } srma_hstate_t;

    srma_hstate_t st_r, st_nxt;
    logic [3:0] div_r, div_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [15:0] cmd_r, cmd_nxt;
    logic [15:0] resp_r, resp_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic sclk_r, sclk_nxt;
    logic csn_r, csn_nxt;
    logic mosi_r, mosi_nxt;
    logic s_miso;
    logic half_done;

    srma_sync #(.W(1), .INIT(1'b0)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(link.miso),
        .q(s_miso)
    );

    assign half_done = div_r == 4'(SCLK_HALF_CYC - 1);

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        div_nxt = half_done ? 4'h0 : div_r + 4'h1;
        bit_nxt = bit_r;
        cmd_nxt = cmd_r;
        resp_nxt = resp_r;
        sclk_nxt = sclk_r;
        csn_nxt = csn_r;
        mosi_nxt = mosi_r;
        rdata_nxt = 16'h0000;
        if (sw_rd) begin
            if (sw_addr == H_CMD) rdata_nxt = cmd_r;
            else if (sw_addr == H_STATUS)
                rdata_nxt = {15'h0000, st_r != SRMA_IDLE};
            else if (sw_addr == H_RESP) rdata_nxt = resp_r;
            else rdata_nxt = 16'h0000;
        end
        case (st_r)
            SRMA_IDLE: begin
                div_nxt = 4'h0;
                if (sw_wr && sw_addr == H_CMD) begin
                    // frame word: address 6:0, selector 7, data 15:8
                    cmd_nxt = sw_wdata;
                    csn_nxt = 1'b0;
                    mosi_nxt = sw_wdata[0];
                    bit_nxt = 4'h0;
                    st_nxt = SRMA_LEAD;
                end
            end
            SRMA_LEAD, SRMA_LOW: begin
                if (half_done) begin
                    sclk_nxt = 1'b1;
                    st_nxt = SRMA_HIGH;
                end
            end
            SRMA_HIGH: begin
                if (half_done) begin
                    resp_nxt[bit_r] = s_miso;
                    sclk_nxt = 1'b0;
                    bit_nxt = bit_r + 4'h1;
                    if (bit_r == 4'hf) begin
                        st_nxt = SRMA_TRAIL;
                    end else begin
                        mosi_nxt = cmd_r[bit_r + 4'h1];
                        st_nxt = SRMA_LOW;
                    end
                end
            end
            SRMA_TRAIL: begin
                if (half_done) begin
                    csn_nxt = 1'b1;
                    mosi_nxt = 1'b0;
                    st_nxt = SRMA_GAP;
                end
            end
            SRMA_GAP: begin
                if (half_done) st_nxt = SRMA_IDLE;
            end
            default: st_nxt = SRMA_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= SRMA_IDLE;
            div_r <= 4'h0;
            bit_r <= 4'h0;
            cmd_r <= 16'h0000;
            resp_r <= 16'h0000;
            rdata_r <= 16'h0000;
            sclk_r <= 1'b0;
            csn_r <= 1'b1;
            mosi_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            div_r <= div_nxt;
            bit_r <= bit_nxt;
            cmd_r <= cmd_nxt;
            resp_r <= resp_nxt;
            rdata_r <= rdata_nxt;
            sclk_r <= sclk_nxt;
            csn_r <= csn_nxt;
            mosi_r <= mosi_nxt;
        end
    end

    assign link.sclk = sclk_r;
    assign link.csn_n = csn_r;
    assign link.mosi = mosi_r;
    assign sw_rdata = rdata_r;

endmodule

// [core/srma_link_if.sv]
// serial link between the controller and the register bank.
// assumes both ends sit on the same board clock; the link clock is a pin.
`timescale 1ns/1ps
interface srma_link_if;
    logic sclk;
    logic csn_n;
    logic mosi;
    logic miso;

    modport dev (
        input sclk,
        input csn_n,
        input mosi,
        output miso
    );

    modport host (
        output sclk,
        output csn_n,
        output mosi,
        input miso
    );
endinterface

// [core/srma_pkg.sv]
// package of the serial register access block: frame layout, address map,
// field masks, mode codes and link timing.
// assumes a 50 MHz system clock on both ends of the link.
package srma_pkg;

    // ------------------------------------------------------------
    // frame layout, sent and answered least significant bit first
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int ADDR_LSB = 0;
    localparam int ADDR_W = 7;
    localparam int SEL_POS = 7;
    localparam int DATA_LSB = 8;
    localparam logic [4:0] FRAME_CNT = 5'h10;

    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam logic [6:0] CTRL_LAST = 7'h1e;
    localparam int CTRL_N = 31;
    localparam logic [6:0] STAT_FIRST = 7'h40;
    localparam logic [6:0] STAT_LAST = 7'h7e;
    localparam logic [6:0] A_MODE_SUPPLY = 7'h00;
    localparam logic [6:0] A_HW_CFG = 7'h01;
    localparam logic [6:0] A_WDOG_CFG = 7'h02;
    localparam logic [6:0] A_BUS_CFG_A = 7'h03;
    localparam logic [6:0] A_BUS_CFG_B = 7'h04;
    localparam logic [6:0] A_WAKE_CFG_A = 7'h05;
    localparam logic [6:0] A_WAKE_CFG_B = 7'h06;
    localparam logic [6:0] A_WAKE_PULL = 7'h08;
    localparam logic [6:0] A_WAKE_FILT = 7'h09;
    localparam logic [6:0] A_TIMER_A = 7'h0c;
    localparam logic [6:0] A_TIMER_B = 7'h0d;
    localparam logic [6:0] A_SW_SHUTDOWN = 7'h10;
    localparam logic [6:0] A_HS_CFG_A = 7'h14;
    localparam logic [6:0] A_HS_CFG_B = 7'h15;
    localparam logic [6:0] A_GPIO_CFG = 7'h17;
    localparam logic [6:0] A_PWM_A = 7'h18;
    localparam logic [6:0] A_PWM_B = 7'h19;
    localparam logic [6:0] A_PWM_FREQ = 7'h1c;
    localparam logic [6:0] A_SCRATCH = 7'h1e;
    // clearable status registers, index order 0..8
    localparam int STAT_N = 9;
    localparam logic [6:0] A_SUPPLY_B = 7'h40;
    localparam logic [6:0] A_SUPPLY_A = 7'h41;
    localparam logic [6:0] A_THERMAL = 7'h42;
    localparam logic [6:0] A_DEVICE = 7'h43;
    localparam logic [6:0] A_BUS_FAIL = 7'h44;
    localparam logic [6:0] A_WAKE_SRC_A = 7'h46;
    localparam logic [6:0] A_WAKE_SRC_B = 7'h47;
    localparam logic [6:0] A_HS_OVERLOAD = 7'h54;
    localparam logic [6:0] A_HS_OPENLOAD = 7'h55;
    // live registers that never clear, index order 0..4
    localparam int LIVE_N = 5;
    localparam logic [6:0] A_WAKE_LEVEL = 7'h48;
    localparam logic [6:0] A_SW_FILTER = 7'h70;
    localparam logic [6:0] A_SW_ERRCNT = 7'h71;
    localparam logic [6:0] A_SW_CLKREC_A = 7'h72;
    localparam logic [6:0] A_SW_CLKREC_B = 7'h73;
    localparam logic [6:0] A_FAMILY_ID = 7'h7e;
    // arbitrary neutral identity value
    localparam logic [7:0] FAMILY_ID_VAL = 8'h5a;

    // ------------------------------------------------------------
    // writable bits per control register, reserved bits cleared
    // ------------------------------------------------------------
    localparam logic [7:0] M_ALL = 8'hff;
    localparam logic [7:0] M_HW_CFG = 8'hfb;
    localparam logic [7:0] M_WDOG_CFG = 8'hf7;
    localparam logic [7:0] M_BUS_CFG_A = 8'h07;
    localparam logic [7:0] M_BUS_CFG_B = 8'h20;
    localparam logic [7:0] M_WAKE_CFG_A = 8'he4;
    localparam logic [7:0] M_WAKE_LOW6 = 8'h3f;
    localparam logic [7:0] M_TIMER = 8'h77;
    localparam logic [7:0] M_SW_SHUTDOWN = 8'h70;
    localparam logic [7:0] M_HS_CFG = 8'h77;
    localparam logic [7:0] M_PWM_FREQ = 8'h05;
    localparam logic [7:0] M_NONE = 8'h00;

    // ------------------------------------------------------------
    // fields touched by mode changes
    // ------------------------------------------------------------
    localparam int MODE_LSB = 6;
    localparam logic [7:0] M_SUPPLY_CFG = 8'h38;
    localparam logic [7:0] M_SECOND_SUPPLY = 8'h18;
    localparam logic [2:0] CAN_OFF = 3'h0;
    localparam logic [2:0] CAN_WAKE_CAPABLE = 3'h1;
    localparam int HS_FIELD_W = 4;

    typedef enum logic [1:0] {
        SRMA_NORMAL = 2'h0,
        SRMA_STOP = 2'h1,
        SRMA_SLEEP = 2'h2,
        SRMA_RESTART = 2'h3
    } srma_mode_t;

    // ------------------------------------------------------------
    // link timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 20;
    localparam int SCLK_HALF_NS = 80;
    localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CLK_NS;

    // host command port
    localparam logic [1:0] H_CMD = 2'h0;
    localparam logic [1:0] H_STATUS = 2'h1;
    localparam logic [1:0] H_RESP = 2'h2;

endpackage

// [core/srma_sync.sv]
// two-stage synchroniser for pin inputs.
// assumes the inputs are asynchronous levels; q is valid two edges later.
`timescale 1ns/1ps
module srma_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= INIT;
            q_r <= INIT;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule

// [test/spi_register_map_access_bench.sv]
// bench: host and register bank face each other over the link.
// assumes software drives the host port; device inputs come from here.
`timescale 1ns/1ps
module spi_register_map_access_bench
    import srma_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, mode_chg = 1'b0, fail_trig = 1'b0;
    logic sw_wr = 1'b0, sw_rd = 1'b0, rd_r = 1'b0, fail_output, frame_err;
    logic [1:0] mode_in = 2'h0, sw_addr = 2'h0;
    logic [8*STAT_N-1:0] stat_evt = 72'h0;
    logic [8*LIVE_N-1:0] live_in = 40'h0;
    logic [3:0] hs_fault = 4'h0;
    logic [15:0] sw_wdata = 16'h0, sw_rdata;
    logic [8*CTRL_N-1:0] ctrl_cfg;
    logic [15:0] exp_q[$];
    logic [7:0] d;
    logic [6:0] ta [4] = '{7'h1e, 7'h01, 7'h04, 7'h07};
    logic [7:0] tm [4] = '{M_ALL, M_HW_CFG, M_BUS_CFG_B, M_NONE};
    int bad_count = 0, n_tests = 0, cyc = 0;
    srma_link_if link ();
    srma_device i_srma_device (.clk(clk), .rst_n(rst_n), .link(link.dev),
        .mode_chg(mode_chg), .mode_in(mode_in), .stat_evt(stat_evt),
        .live_in(live_in), .hs_fault(hs_fault), .fail_trig(fail_trig),
        .ctrl_cfg(ctrl_cfg), .fail_output(fail_output), .frame_err(frame_err));
    srma_host i_srma_host (.clk(clk), .rst_n(rst_n), .link(link.host),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
        .sw_rd(sw_rd), .sw_rdata(sw_rdata));
    srma_link_monitor i_srma_link_monitor (.clk(clk), .rst_n(rst_n),
        .sclk(link.sclk), .csn_n(link.csn_n), .mosi(link.mosi),
        .miso(link.miso));
    initial forever #10 clk = ~clk;
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("mismatches %0d of %0d checks", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one frame: command, poll busy, fetch response
    task automatic frame(input logic [6:0] a, input logic s,
                         input logic [7:0] v, input logic [15:0] e);
        exp_q.push_back(e);
        @(posedge clk) {sw_addr, sw_wdata, sw_wr} <= {H_CMD, v, s, a, 1'b1};
        @(posedge clk) sw_wr <= 1'b0;
        repeat (4) @(posedge clk);
        do begin
            @(posedge clk) {sw_addr, sw_rd} <= {H_STATUS, 1'b1};
            @(posedge clk) sw_rd <= 1'b0;
            @(negedge clk);
        end while (sw_rdata[0] !== 1'b0);
        @(posedge clk) {sw_addr, sw_rd} <= {H_RESP, 1'b1};
        @(posedge clk) sw_rd <= 1'b0;
    endtask
    task automatic mode(input srma_mode_t m);
        @(posedge clk) {mode_in, mode_chg} <= {m, 1'b1};
        @(posedge clk) mode_chg <= 1'b0;
    endtask
    always @(posedge clk) rd_r <= sw_rd && sw_addr == H_RESP;
    always @(negedge clk)
        if (rd_r) check("resp", sw_rdata, exp_q.pop_front());
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            test_done;
        end
    end
    initial begin
        void'($urandom(32'hc0ad));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            d = 8'($urandom);
            frame(ta[k], 1'b1, d, 16'h0000);
            frame(ta[k], 1'b0, ~d, {d & tm[k], 8'h00});
            check("cfg", 16'(ctrl_cfg[8*ta[k]+:8]), 16'(d & tm[k]));
        end
        d = 8'($urandom) | 8'h01;
        @(posedge clk) {stat_evt[15:8], live_in[7:0]} <= {d, ~d};
        @(posedge clk) stat_evt <= 72'h0;
        frame(A_SUPPLY_A, 1'b0, 8'h00, {d, 8'h01});
        frame(A_SUPPLY_A, 1'b1, 8'h00, {d, 8'h01});
        frame(A_SUPPLY_A, 1'b0, 8'h00, 16'h0000);
        frame(A_WAKE_LEVEL, 1'b1, 8'h00, {~d, 8'h00});
        frame(A_WAKE_LEVEL, 1'b0, 8'h00, {~d, 8'h00});
        frame(A_FAMILY_ID, 1'b1, 8'h00, {FAMILY_ID_VAL, 8'h00});
        frame(A_BUS_CFG_A, 1'b1, 8'h05, 16'h0000);
        mode(SRMA_STOP);
        frame(A_BUS_CFG_A, 1'b0, 8'h00, 16'h0500);
        mode(SRMA_SLEEP);
        frame(A_BUS_CFG_A, 1'b0, 8'h00, 16'h0100);
        frame(A_HS_CFG_A, 1'b1, 8'h77, 16'h0000);
        frame(A_MODE_SUPPLY, 1'b0, 8'h00, 16'h8000);
        mode(SRMA_NORMAL);
        frame(A_HS_CFG_A, 1'b1, 8'h77, 16'h0000);
        @(posedge clk) {hs_fault, fail_trig} <= {4'h1, 1'b1};
        @(posedge clk) {hs_fault, fail_trig} <= {4'h0, 1'b0};
        frame(A_HS_CFG_A, 1'b0, 8'h00, 16'h7000);
        mode(SRMA_RESTART);
        mode(SRMA_NORMAL);
        frame(A_HS_CFG_A, 1'b0, 8'h00, 16'h0000);
        check("fail", {15'h0, fail_output}, 16'h0001);
        check("err", {15'h0, frame_err}, 16'h0000);
        test_done;
    end
endmodule

// [test/srma_link_monitor.sv]
// link checker beside the interface joining host and register bank.
// assumes clk samples every link pin directly.
`timescale 1ns/1ps
module srma_link_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link
    input wire logic sclk,
    input wire logic csn_n,
    input wire logic mosi,
    input wire logic miso
);
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic sclk_r;
    // counts link clock rises inside a frame
    always_comb begin
        cnt_nxt = csn_n ? 5'h00 : cnt_r + {4'h0, sclk & ~sclk_r};
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 5'h00;
            sclk_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            sclk_r <= sclk;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_len; $rose(csn_n) |-> cnt_r == 5'h10; endproperty
    a_len: assert property (p_len) else $error("clock count");
    property p_idle; csn_n |-> !sclk; endproperty
    a_idle: assert property (p_idle) else $error("clock idle");
    property p_lead; $fell(csn_n) |-> !sclk [*4] ##1 sclk; endproperty
    a_lead: assert property (p_lead) else $error("lead time");
    property p_tail; $rose(csn_n) |-> !$past(sclk) && !$past(sclk, 4);
    endproperty
    a_tail: assert property (p_tail) else $error("tail time");
    property p_high; $rose(sclk) |=> sclk [*3] ##1 !sclk; endproperty
    a_high: assert property (p_high) else $error("clock high");
    property p_mosi; sclk |-> $stable(mosi); endproperty
    a_mosi: assert property (p_mosi) else $error("mosi moved");
    property p_miso; sclk && $past(sclk) |-> $stable(miso); endproperty
    a_miso: assert property (p_miso) else $error("miso moved");
    property p_quiet; csn_n [*6] |-> !miso; endproperty
    a_quiet: assert property (p_quiet) else $error("miso busy");
endmodule
